/* hw/plc_pkg.sv */
// Constants, register map and state encoding for the position latch capture block.
// Assumes a single 25 MHz clock domain and a classic Wishbone register slave.
// Functional notes
// - Done rises once the trigger has occurred and the position is captured.
// - Done drops when execute falls; with execute low, done lasts one cycle.
// - Busy rises on a rising edge of execute.
// - Busy clears on done, error or abort, whichever comes first.
// - Error and a fault code are raised for invalid conditions or inputs.
// - Error and fault code clear when execute falls.
// - Abort flag sets when the cancel command aborts an active request.
// - Abort flag drops when execute falls; with execute low, one cycle only.
// - Captured position is output; it reads zero before any capture.
// - Descriptor sampled only on execute rise with busy low.
// - With location select true, latching happens in the drive channel.
// - With location select false, the soft trigger bit latches here.
// - Drive mode with negative channel reports an error, no capture.
// - Only the first valid trigger per request is taken.
// - Drive latch value is divided by the gear ratio before output.
// - With window gate on, triggers outside the bounds are rejected.
package plc_pkg;
	localparam int POS_W = 32;
	localparam int AW = 4;
	// Word offsets (byte address = 4 * index)
	localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
	localparam logic [AW-1:0] ADDR_STATUS = 4'h1;
	localparam logic [AW-1:0] ADDR_FAULT = 4'h2;
	localparam logic [AW-1:0] ADDR_POS = 4'h3;
	localparam logic [AW-1:0] ADDR_LOWER = 4'h4;
	localparam logic [AW-1:0] ADDR_UPPER = 4'h5;
	localparam logic [AW-1:0] ADDR_GEAR = 4'h6;
	localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'h7;
	localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'h8;
	// Control register fields
	localparam int CTRL_EXEC = 0;
	localparam int CTRL_LOC = 1;
	localparam int CTRL_SOFT = 2;
	localparam int CTRL_VALID = 3;
	localparam int CTRL_WIN = 4;
	localparam int CTRL_CANCEL = 5;
	localparam int CTRL_CH_LSB = 8;
	localparam int CTRL_CH_W = 16;
	// Control reset: location select true, channel 16'hff00 (-256)
	localparam logic [31:0] CTRL_RST = 32'hffff_0002;
	// Status register fields
	localparam int ST_DONE = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_ERR = 2;
	localparam int ST_ABORT = 3;
	// Interrupt event bits
	localparam int EV_DONE = 0;
	localparam int EV_ERR = 1;
	localparam int EV_ABORT = 2;
	localparam int EV_W = 3;
	// Fault codes
	typedef enum logic [7:0] {
		FAULT_NONE = 8'h00,
		FAULT_BAD_CHANNEL = 8'h01,
		FAULT_BAD_DESC = 8'h02,
		FAULT_BAD_WINDOW = 8'h03,
		FAULT_BAD_GEAR = 8'h04
	} plc_fault_e;
	localparam logic [31:0] GEAR_RST = 32'h0000_0001;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// Request states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_DIVIDE = 4'b0100,
		ST_HOLD = 4'b1000
	} plc_state_e;
endpackage

/* hw/plc_core.sv */
// Position latch capture block with execute/done/busy handshake and Wishbone slave.
// Assumes drive probe inputs and axis position come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module plc_core
	import plc_pkg::*;
#(
	parameter int POS_WIDTH = POS_W,
	parameter int DIV_STEPS = POS_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Drive side latch channels (probe1 rise, probe1 fall, probe2 rise, probe2 fall)
	input wire logic [3:0] drive_latch_event_i,
	input wire logic [31:0] drive_latch_value_i,
	input wire logic drive_window_support_i,
	input wire logic [31:0] axis_position_i,
	output logic [3:0] drive_channel_open_o,
	// Handshake mirrors of status
	output logic done_o,
	output logic busy_o,
	output logic error_o,
	output logic abort_flag_o,
	output logic [7:0] fault_code_o,
	output logic [31:0] captured_position_o,
	output logic irq_o
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] lower;
		logic [31:0] upper;
		logic [31:0] gear;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_mask;
		logic ack;
		logic [31:0] rdata;
		logic exec_d;
		plc_state_e state;
		logic done;
		logic busy;
		logic error;
		logic abort_flag;
		plc_fault_e fault;
		logic [31:0] position;
		// Descriptor latched at request start
		logic loc;
		logic [1:0] chan;
		logic win;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] gdiv;
		logic soft_d;
		// Divider working set
		logic [31:0] quot;
		logic [31:0] rem;
		logic [5:0] steps;
		// Synchronisers
		logic [3:0] ev_s1;
		logic [3:0] ev_s2;
		logic [3:0] ev_s3;
		logic [31:0] val_s1;
		logic [31:0] val_s2;
		logic [31:0] pos_s1;
		logic [31:0] pos_s2;
		logic win_s1;
		logic win_s2;
	} plc_s;

	plc_s r_reg;
	plc_s r_next;

	logic [AW-1:0] widx;
	logic wr_hit;
	logic rd_hit;
	logic exec_now;
	logic exec_rise;
	logic exec_fall;
	logic in_window;
	logic drv_hit;
	logic soft_hit;
	logic [EV_W-1:0] ev;
	logic [31:0] ctrl_wr;
	logic [32:0] trial;

	assign widx = wb_adr_i[AW+1:2];
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !r_reg.ack;
	assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !r_reg.ack;
	assign exec_now = r_reg.ctrl[CTRL_EXEC];
	assign exec_rise = exec_now && !r_reg.exec_d;
	assign exec_fall = !exec_now && r_reg.exec_d;
	// Window test on the synchronised axis position, signed compare
	assign in_window = !r_reg.win ||
		(($signed(r_reg.pos_s2) >= $signed(r_reg.lo)) && ($signed(r_reg.pos_s2) <= $signed(r_reg.hi)));
	// Drive channel edge: new event on the selected channel only
	assign drv_hit = r_reg.ev_s2[r_reg.chan] && !r_reg.ev_s3[r_reg.chan];
	assign soft_hit = r_reg.ctrl[CTRL_SOFT] && !r_reg.soft_d && r_reg.ctrl[CTRL_VALID];
	assign trial = {r_reg.rem, r_reg.quot[31]} - {1'b0, r_reg.gdiv};

	// Byte-lane merge for control writes
	always_comb begin
		ctrl_wr = r_reg.ctrl;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				ctrl_wr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
			end
		end
	end

	// Whole next-state computation
	always_comb begin
		r_next = r_reg;
		ev = '0;
		// Synchronisers: first stage read only by second
		r_next.ev_s1 = drive_latch_event_i;
		r_next.ev_s2 = r_reg.ev_s1;
		r_next.ev_s3 = r_reg.ev_s2;
		r_next.val_s1 = drive_latch_value_i;
		r_next.val_s2 = r_reg.val_s1;
		r_next.pos_s1 = axis_position_i;
		r_next.pos_s2 = r_reg.pos_s1;
		r_next.win_s1 = drive_window_support_i;
		r_next.win_s2 = r_reg.win_s1;
		r_next.exec_d = exec_now;
		r_next.soft_d = r_reg.ctrl[CTRL_SOFT];
		// Bus: one-cycle ack, answer every address; unmapped reads zero
		r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
		r_next.rdata = ZERO32;
		r_next.ctrl[CTRL_CANCEL] = 1'b0; // Cancel is a self-clearing strobe
		if (wr_hit) begin
			case (widx)
				ADDR_CTRL: r_next.ctrl = ctrl_wr;
				ADDR_LOWER: r_next.lower = wb_dat_i;
				ADDR_UPPER: r_next.upper = wb_dat_i;
				ADDR_GEAR: r_next.gear = wb_dat_i;
				ADDR_IRQ_MASK: r_next.irq_mask = wb_dat_i[EV_W-1:0];
				default: ;
			endcase
		end
		if (rd_hit) begin
			case (widx)
				ADDR_CTRL: r_next.rdata = r_reg.ctrl;
				ADDR_STATUS: r_next.rdata = {28'h0000000, r_reg.abort_flag, r_reg.error, r_reg.busy, r_reg.done};
				ADDR_FAULT: r_next.rdata = {24'h000000, r_reg.fault};
				ADDR_POS: r_next.rdata = r_reg.position;
				ADDR_LOWER: r_next.rdata = r_reg.lower;
				ADDR_UPPER: r_next.rdata = r_reg.upper;
				ADDR_GEAR: r_next.rdata = r_reg.gear;
				ADDR_IRQ_STAT: r_next.rdata = {29'h0000000, r_reg.irq_stat};
				ADDR_IRQ_MASK: r_next.rdata = {29'h0000000, r_reg.irq_mask};
				default: r_next.rdata = ZERO32;
			endcase
		end
		// One-scan pulses end here when execute is already low
		if (!exec_now) begin
			r_next.done = 1'b0;
			r_next.abort_flag = 1'b0;
		end
		if (exec_fall) begin
			r_next.error = 1'b0;
			r_next.fault = FAULT_NONE;
		end
		// Request engine
		case (r_reg.state)
			ST_IDLE: begin
				if (exec_rise && !r_reg.busy) begin
					// Descriptor frozen for the whole request
					r_next.loc = r_reg.ctrl[CTRL_LOC];
					r_next.chan = r_reg.ctrl[CTRL_CH_LSB +: 2];
					r_next.win = r_reg.ctrl[CTRL_WIN];
					r_next.lo = r_reg.lower;
					r_next.hi = r_reg.upper;
					r_next.gdiv = r_reg.gear;
					r_next.done = 1'b0;
					r_next.abort_flag = 1'b0;
					r_next.error = 1'b0;
					r_next.fault = FAULT_NONE;
					if (r_reg.ctrl[CTRL_LOC] && r_reg.ctrl[CTRL_CH_LSB+CTRL_CH_W-1]) begin
						r_next.fault = FAULT_BAD_CHANNEL;
					end else if (r_reg.ctrl[CTRL_LOC] && (r_reg.ctrl[CTRL_CH_LSB +: CTRL_CH_W] > 16'h0003)) begin
						r_next.fault = FAULT_BAD_DESC;
					end else if (r_reg.ctrl[CTRL_LOC] && r_reg.gear == ZERO32) begin
						r_next.fault = FAULT_BAD_GEAR;
					end else if (r_reg.ctrl[CTRL_WIN] && r_reg.ctrl[CTRL_LOC] && !r_reg.win_s2) begin
						r_next.fault = FAULT_BAD_WINDOW;
					end
					if (r_next.fault != FAULT_NONE) begin
						r_next.error = 1'b1;
						ev[EV_ERR] = 1'b1;
					end else begin
						r_next.busy = 1'b1;
						r_next.state = ST_ARMED;
					end
				end
			end
			ST_ARMED: begin
				if (r_reg.ctrl[CTRL_CANCEL]) begin
					r_next.abort_flag = 1'b1;
					r_next.busy = 1'b0;
					ev[EV_ABORT] = 1'b1;
					r_next.state = ST_IDLE;
				end else if (r_reg.loc && drv_hit && in_window) begin
					// First accepted latch only; later edges never sampled
					r_next.quot = r_reg.val_s2;
					r_next.rem = ZERO32;
					r_next.steps = DIV_STEPS[5:0];
					r_next.state = ST_DIVIDE;
				end else if (!r_reg.loc && soft_hit && in_window) begin
					r_next.position = r_reg.pos_s2;
					r_next.done = 1'b1;
					r_next.busy = 1'b0;
					ev[EV_DONE] = 1'b1;
					r_next.state = ST_IDLE;
				end
			end
			ST_DIVIDE: begin
				// Restoring divide, one bit per cycle, trades latency for area
				if (!trial[32]) begin
					r_next.rem = trial[31:0];
					r_next.quot = {r_reg.quot[30:0], 1'b1};
				end else begin
					r_next.rem = {r_reg.rem[30:0], r_reg.quot[31]};
					r_next.quot = {r_reg.quot[30:0], 1'b0};
				end
				r_next.steps = r_reg.steps - 6'h01;
				if (r_reg.steps == 6'h01) begin
					r_next.state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				r_next.position = r_reg.quot;
				r_next.done = 1'b1;
				r_next.busy = 1'b0;
				ev[EV_DONE] = 1'b1;
				r_next.state = ST_IDLE;
			end
			default: r_next.state = ST_IDLE;
		endcase
		// Sticky events, read clears; a new event wins over the clear
		if (rd_hit && widx == ADDR_IRQ_STAT) begin
			r_next.irq_stat = ev;
		end else begin
			r_next.irq_stat = r_reg.irq_stat | ev;
		end
	end

	// Single register stage, frozen by clock enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
			r_reg.ctrl <= CTRL_RST;
			r_reg.gear <= GEAR_RST;
			r_reg.gdiv <= GEAR_RST;
			r_reg.state <= ST_IDLE;
			r_reg.fault <= FAULT_NONE;
			r_reg.loc <= 1'b1;
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	// Drive channel opened only while busy in drive mode
	always_comb begin
		drive_channel_open_o = 4'h0;
		if (r_reg.busy && r_reg.loc) begin
			drive_channel_open_o[r_reg.chan] = 1'b1;
		end
	end

	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = r_reg.rdata;
	assign done_o = r_reg.done;
	assign busy_o = r_reg.busy;
	assign error_o = r_reg.error;
	assign abort_flag_o = r_reg.abort_flag;
	assign fault_code_o = r_reg.error ? r_reg.fault : FAULT_NONE;
	assign captured_position_o = r_reg.position;
	assign irq_o = |(r_reg.irq_stat & r_reg.irq_mask);
endmodule
`default_nettype wire

/* dv/plc_core_sva.sv */
// Checker on the ports of the position latch capture block.
// Assumes one clock domain and a bind onto plc_core.
`timescale 1ns/1ps
`default_nettype none
module plc_core_sva
	import plc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [3:0] drive_channel_open_o,
	input wire logic done_o,
	input wire logic busy_o,
	input wire logic error_o,
	input wire logic abort_flag_o,
	input wire logic [7:0] fault_code_o,
	input wire logic [31:0] captured_position_o
);
	// One clock, one reset for every check
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Bus answers after one cycle and never stretches its pulse
	AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	// Busy gives way to any of the three end states
	AST_BUSY_DONE: assert property (done_o |-> !busy_o)
		else $error("busy with done");
	AST_BUSY_ERR: assert property (error_o |-> !busy_o)
		else $error("busy with error");
	AST_BUSY_ABORT: assert property (abort_flag_o |-> !busy_o)
		else $error("busy with abort");
	AST_DONE_CAUSE: assert property ($rose(done_o) |-> $past(busy_o))
		else $error("done without a request");
	AST_ERR_CODE: assert property (error_o |-> fault_code_o != FAULT_NONE)
		else $error("error without a code");
	AST_CODE_IDLE: assert property (!error_o |-> fault_code_o == FAULT_NONE)
		else $error("fault code outside error");
	AST_CODE_HOLD: assert property (error_o && $past(error_o) |-> $stable(fault_code_o))
		else $error("fault code moved during error");
	AST_POS_CAUSE: assert property ($changed(captured_position_o) |-> $past(busy_o))
		else $error("position moved outside a request");
	AST_ONE_CHANNEL: assert property ($onehot0(drive_channel_open_o))
		else $error("several channels open");
	// Main scenarios reached
	COV_DONE: cover property ($rose(done_o));
	COV_ERR: cover property ($rose(error_o));
	COV_ABORT: cover property ($rose(abort_flag_o));
endmodule
bind plc_core plc_core_sva i_sva (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .drive_channel_open_o,
	.done_o, .busy_o, .error_o, .abort_flag_o, .fault_code_o, .captured_position_o);
`default_nettype wire

/* dv/plc_drive_model.sv */
// Behavioural servo drive: latches on the opened probe channel when told to fire.
// Assumes the bench pulses fire_i for one cycle; lacks window gating support.
`timescale 1ns/1ps
`default_nettype none
module plc_drive_model (
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic [3:0] delay_i,
	input wire logic [31:0] fire_value_i,
	input wire logic [31:0] axis_i,
	input wire logic [3:0] channel_open_i,
	output logic [3:0] latch_event_o,
	output logic [31:0] latch_value_o,
	output logic window_support_o,
	output logic [31:0] axis_position_o
);
	assign axis_position_o = axis_i;
	// Idle lines at start; no window gating in this drive
	initial begin
		latch_event_o = 4'h0;
		latch_value_o = 32'h0000_0000;
		window_support_o = 1'b0;
	end
	// Latch only on the opened channel; value set up before the strobe, spoilt after
	always @(posedge clk_i) begin
		if (fire_i && channel_open_i != 4'h0) begin
			latch_value_o <= fire_value_i;
			repeat (4 + delay_i) @(posedge clk_i);
			latch_event_o <= channel_open_i;
			repeat (4) @(posedge clk_i);
			latch_event_o <= 4'h0;
			latch_value_o <= ~fire_value_i; // Hold time over
		end
	end
endmodule
`default_nettype wire

/* dv/position_latch_capture_test.sv */
// Self-checking bench for the position latch capture block.
// Assumes plc_core, its checker and the drive model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module position_latch_capture_test
	import plc_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, ack, fire, done, busy, err, abt, irq, ws;
	logic [5:0] adr;
	logic [31:0] dw, dr, q, lv, ax, apos, fval, pos;
	logic [3:0] ev, chopen;
	logic [7:0] fc;
	logic [3:0] flg;
	int fails, check_count;
	assign flg = {abt, err, busy, done};
	plc_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.drive_latch_event_i(ev), .drive_latch_value_i(lv), .drive_window_support_i(ws),
		.axis_position_i(ax), .drive_channel_open_o(chopen), .done_o(done), .busy_o(busy), .error_o(err),
		.abort_flag_o(abt), .fault_code_o(fc), .captured_position_o(pos), .irq_o(irq));
	plc_drive_model i_drive (.clk_i(clk_i), .fire_i(fire), .delay_i(4'h6), .fire_value_i(fval), .axis_i(apos),
		.channel_open_i(chopen), .latch_event_o(ev), .latch_value_o(lv), .window_support_o(ws),
		.axis_position_o(ax));
	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One classic cycle; held until ack is sampled high
	task automatic wb(input logic [3:0] idx, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dw <= d;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack === 1'b1) begin
				q = dr;
				cyc <= 1'b0;
				stb <= 1'b0;
				we <= 1'b0;
				return;
			end
		end
		fails++;
		tally_and_finish();
	endtask
	// Bounded wait on done, busy, error or abort
	task automatic wait_bit(input int b);
		for (int n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (flg[b] === 1'b1) return;
		end
		fails++;
		tally_and_finish();
	endtask
	function automatic logic [31:0] ctl(input logic [5:0] bits, input logic [15:0] ch);
		return {8'h00, ch, 2'b00, bits};
	endfunction
	task automatic t_reset();
		wb(ADDR_CTRL, 1'b0, 0); chk("ctrl", CTRL_RST, q);
		wb(ADDR_GEAR, 1'b0, 0); chk("gear", GEAR_RST, q);
		wb(ADDR_POS, 1'b0, 0); chk("position", ZERO32, q);
		wb(4'hf, 1'b0, 0); chk("unmapped", ZERO32, q);
	endtask
	task automatic t_soft();
		apos <= 32'h0000_1234;
		wb(ADDR_IRQ_MASK, 1'b1, 32'h1);
		wb(ADDR_CTRL, 1'b1, ctl(6'h09, 16'hffff));
		wait_bit(1);
		wb(ADDR_CTRL, 1'b1, ctl(6'h0d, 16'hffff));
		wait_bit(0);
		@(posedge clk_i);
		chk("position", 32'h0000_1234, pos);
		chk("busy", 0, busy);
		apos <= 32'h0000_5678;
		wb(ADDR_CTRL, 1'b1, ctl(6'h09, 16'hffff));
		wb(ADDR_CTRL, 1'b1, ctl(6'h0d, 16'hffff));
		repeat (6) @(posedge clk_i);
		chk("second trigger", 32'h0000_1234, pos);
		chk("irq", 1, irq);
		wb(ADDR_IRQ_STAT, 1'b0, 0); chk("irq status", 32'h1, q);
		wb(ADDR_CTRL, 1'b1, ctl(6'h08, 16'hffff));
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 0, irq);
		chk("done after release", 0, done);
	endtask
	// Soft trigger outside the window is ignored, inside it is taken
	task automatic t_window();
		wb(ADDR_LOWER, 1'b1, 32'h0000_0100);
		wb(ADDR_UPPER, 1'b1, 32'h0000_0200);
		apos <= 32'h0000_0050;
		wb(ADDR_CTRL, 1'b1, ctl(6'h19, 16'hffff));
		wait_bit(1);
		wb(ADDR_CTRL, 1'b1, ctl(6'h1d, 16'hffff));
		repeat (4) @(posedge clk_i);
		chk("busy outside window", 1, busy);
		chk("done outside window", 0, done);
		apos <= 32'h0000_0150;
		repeat (4) @(posedge clk_i);
		wb(ADDR_CTRL, 1'b1, ctl(6'h19, 16'hffff));
		// Execute drops with the trigger, so done lasts one cycle
		wb(ADDR_CTRL, 1'b1, ctl(6'h1c, 16'hffff));
		wait_bit(0);
		@(posedge clk_i);
		chk("done one scan", 0, done);
		chk("window position", 32'h0000_0150, pos);
	endtask
	task automatic t_err();
		logic [31:0] c[4] = '{ctl(6'h01, 16'hffff), ctl(6'h01, 16'h0004), ctl(6'h11, 16'h0000),
			ctl(6'h01, 16'h0001)};
		logic [7:0] f[4] = '{FAULT_BAD_CHANNEL, FAULT_BAD_DESC, FAULT_BAD_WINDOW, FAULT_BAD_GEAR};
		for (int i = 0; i < 4; i++) begin
			// Last case needs a zero divisor; the drive test restores it
			if (i == 3) begin
				wb(ADDR_GEAR, 1'b1, ZERO32);
			end
			wb(ADDR_CTRL, 1'b1, c[i] | 32'h2);
			wait_bit(2);
			chk("fault", f[i], fc);
			wb(ADDR_CTRL, 1'b1, c[i] & 32'hfffffffe);
			repeat (2) @(posedge clk_i);
			chk("error cleared", 0, err);
			chk("fault cleared", 0, fc);
		end
	endtask
	task automatic t_drive();
		wb(ADDR_GEAR, 1'b1, 32'h0000_0004);
		wb(ADDR_CTRL, 1'b1, ctl(6'h03, 16'h0002));
		wait_bit(1);
		repeat (2) @(posedge clk_i);
		chk("channel", 32'h4, chopen);
		fval <= 32'h0000_03e8;
		fire <= 1'b1;
		@(posedge clk_i);
		fire <= 1'b0;
		wait_bit(0);
		@(posedge clk_i);
		chk("geared position", 32'h0000_00fa, pos);
		wb(ADDR_CTRL, 1'b1, ctl(6'h02, 16'h0002));
	endtask
	task automatic t_abort();
		wb(ADDR_CTRL, 1'b1, ctl(6'h09, 16'hffff));
		wait_bit(1);
		wb(ADDR_CTRL, 1'b1, ctl(6'h29, 16'hffff));
		wait_bit(3);
		chk("busy on abort", 0, busy);
		wb(ADDR_CTRL, 1'b1, ctl(6'h08, 16'hffff));
		repeat (2) @(posedge clk_i);
		chk("abort cleared", 0, abt);
		// Cancel together with execute low: abort lasts one cycle
		wb(ADDR_CTRL, 1'b1, ctl(6'h09, 16'hffff));
		wait_bit(1);
		wb(ADDR_CTRL, 1'b1, ctl(6'h28, 16'hffff));
		wait_bit(3);
		@(posedge clk_i);
		chk("abort one scan", 0, abt);
		wb(ADDR_IRQ_STAT, 1'b0, 0); chk("irq events", 32'h7, q);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, fire} = 4'h0;
		adr = 6'h00;
		dw = ZERO32;
		fval = ZERO32;
		apos = ZERO32;
		fails = 0;
		check_count = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_soft();
		t_window();
		t_err();
		t_drive();
		t_abort();
		tally_and_finish();
	end
endmodule
`default_nettype wire
